// ---- common/lrs_regs.vh ----
// register offsets, field positions, mode register addresses, reset values and timing constants for the lpddr2 refresh block
`ifndef LRS_REGS_VH
`define LRS_REGS_VH
// register byte offsets
`define LRS_CTRL_OFS        8'h00
`define LRS_STAT_OFS        8'h04
`define LRS_BANKMASK_OFS    8'h08
`define LRS_SEGMASK_OFS     8'h0c
`define LRS_REFCNT_OFS      8'h10
`define LRS_MR_ADDR_OFS     8'h14
`define LRS_MR_DATA_OFS     8'h18
// control fields
`define LRS_CTRL_OUT_EN     0
// status fields
`define LRS_STAT_SREF       0
`define LRS_STAT_XSR        1
`define LRS_STAT_MRR        2
`define LRS_STAT_RDPEND     3
// mode register addresses
`define LRS_MR_BANKMASK     8'h10
`define LRS_MR_SEGMASK      8'h11
// reset values
`define LRS_BANKMASK_RST    8'h00
`define LRS_SEGMASK_RST     8'h00
// timing figures
`define LRS_TMRR_CK         3'h2
`define LRS_BURST_BEATS     3'h4
`define LRS_TCKESR_NS       15
`define LRS_TXSR_NS         140
`define LRS_TREFI_NS        7800
`define LRS_CLK_NS          20
`endif

// ---- rtl/lrs_core.v ----
// lpddr2 device-side command decoder: self-refresh, bank masking and mode register read
//
// Added by the designer: the AHB-Lite register port and the address map.
`timescale 1ns/1ns
`include "lrs_regs.vh"
// What this block does
// - self-refresh entry: CKE low, CS_n low, CA0/CA1 low, CA2 high, prior CKE high.
// - in self-refresh device ignores all inputs except CKE, refreshes on internal timer.
// - device refreshes internally within tCKESR; controller stays in at least tCKESR.
// - device does not refresh in power-down; controller limits power-down time.
// - eight-bit register at 10H masks banks; masked banks lose self-refresh refresh.
// - mode register read decode; address from CA1-CA0 falling and CA9-CA4 rising.
// - read value on DQ[7:0] first beat after RL; DQS toggles the whole burst.
// - mode register read is a four-beat uninterrupted burst; tMRR is two cycles.
// - reserved or write-only register read returns defined-but-arbitrary data.
module lrs_core #(
  parameter        RL        = 3,
  parameter [7:0]  FILL_BYTE = 8'ha5,  // arbitrary filler for undefined beats
  parameter        DQW       = 32
) (
  input  wire            ref_clk,
  input  wire            rst_b,
  input  wire            link_ck,
  input  wire            cke,
  input  wire            cs_b,
  input  wire [9:0]      ca,
  output reg  [DQW-1:0]  dq_o,
  output reg             dq_oe,
  output reg             dqs_o,
  output reg             dqs_oe,
  output reg             iref_pulse,
  output reg  [7:0]      bank_refresh,
  input  wire [7:0]      haddr,
  input  wire [1:0]      htrans,
  input  wire            hwrite,
  input  wire [2:0]      hsize,
  input  wire [31:0]     hwdata,
  input  wire            hsel,
  input  wire            hready,
  output reg  [31:0]     hrdata,
  output reg             hreadyout,
  output reg             hresp
);
  localparam integer CKESR_INT = (`LRS_TCKESR_NS + `LRS_CLK_NS - 1) / `LRS_CLK_NS;
  localparam integer TREFI_INT = `LRS_TREFI_NS / `LRS_CLK_NS;
  localparam [15:0]  CKESR_CYC = CKESR_INT[15:0];
  localparam [15:0]  TREFI_CYC = TREFI_INT[15:0];
  localparam [1:0]  ST_ACT = 2'h0, ST_SREF = 2'h1, ST_XSR = 2'h2;

  ////////////////////////////////////////////////////////////////////////////
  // synchronisers: the link runs on its own clock, sampled here
  reg [1:0] ck_s_r, cke_s_r, cs_s_r;
  reg [9:0] ca_m_r, ca_s_r, ca_d_r;  // ca_d_r lines up with ck_d_r: ca just before the edge
  reg       ck_d_r;
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      ck_s_r  <= 2'h0;
      cke_s_r <= 2'h0;
      cs_s_r  <= 2'h3;
      ca_m_r  <= 10'h000;
      ca_s_r  <= 10'h000;
      ca_d_r  <= 10'h000;
      ck_d_r  <= 1'b0;
    end else begin
      ck_s_r  <= {ck_s_r[0], link_ck};
      cke_s_r <= {cke_s_r[0], cke};
      cs_s_r  <= {cs_s_r[0], cs_b};
      ca_m_r  <= ca;
      ca_s_r  <= ca_m_r;
      ca_d_r  <= ca_s_r;
      ck_d_r  <= ck_s_r[1];
    end
  end
  wire ck_rise = ck_s_r[1] & ~ck_d_r;
  wire ck_fall = ~ck_s_r[1] & ck_d_r;
  wire cke_now = cke_s_r[1];
  wire cs_now  = cs_s_r[1];

  ////////////////////////////////////////////////////////////////////////////
  // registers
  reg       out_en_r;
  reg [7:0] bank_mask_r, seg_mask_r, mr_addr_r, mr_data_r;
  reg [1:0] st_r;
  reg [15:0] cnt_r, irefi_r, refcnt_r;
  reg       cke_prev_r, mrr_fall_r, mrr_act_r;
  reg [5:0] mr_hi_r;
  reg [7:0] rl_cnt_r;
  reg [2:0] beat_r, tmrr_r;
  reg       ahb_wr_r;
  reg [7:0] ahb_a_r;

  // mode register contents; reserved or write-only reads give filler
  function [7:0] mr_value;
    input [7:0] a;
    begin
      if (a == `LRS_MR_BANKMASK)
        mr_value = bank_mask_r;
      else if (a == `LRS_MR_SEGMASK)
        mr_value = seg_mask_r;
      else
        mr_value = FILL_BYTE;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // command decode and power states, one decision per link rising edge except self-refresh exit, taken on cke alone
  wire cmd_edge = ck_rise & out_en_r;
  // ca is judged one sample before the edge: the host may move ca on the edge itself
  wire sref_cmd = cmd_edge & cke_prev_r & ~cke_now & ~cs_now
                & ~ca_d_r[0] & ~ca_d_r[1] & ca_d_r[2];
  wire mrr_cmd  = cmd_edge & cke_now & ~cs_now & (ca_d_r[3:0] == 4'h8)
                & (st_r == ST_ACT) & (tmrr_r == 3'h0) & ~mrr_act_r;

  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_r        <= ST_ACT;
      cnt_r       <= 16'h0000;
      irefi_r     <= 16'h0000;
      refcnt_r    <= 16'h0000;
      cke_prev_r  <= 1'b0;
      iref_pulse  <= 1'b0;
      bank_refresh <= 8'h00;
    end else begin
      iref_pulse   <= 1'b0;
      bank_refresh <= 8'h00;
      if (cmd_edge)
        cke_prev_r <= cke_now;
      case (st_r)
        ST_ACT: begin
          // no internal refresh here; power-down keeps cke low without entry
          if (sref_cmd) begin
            st_r    <= ST_SREF;
            cnt_r   <= 16'h0000;
            irefi_r <= 16'h0000;
          end
        end
        ST_SREF: begin
          // internal timer keeps running with the link clock stopped
          cnt_r   <= (cnt_r == 16'hffff) ? cnt_r : cnt_r + 16'h0001;
          irefi_r <= (irefi_r >= TREFI_CYC - 16'h0001) ? 16'h0000 : irefi_r + 16'h0001;
          if (cnt_r == CKESR_CYC - 16'h0001 || irefi_r == TREFI_CYC - 16'h0001) begin
            iref_pulse   <= 1'b1;
            bank_refresh <= ~bank_mask_r;  // masked banks are skipped
            refcnt_r     <= refcnt_r + 16'h0001;
          end
          // only cke is looked at here
          if (cke_now) begin
            st_r  <= ST_XSR;
            cnt_r <= 16'h0000;
          end
        end
        ST_XSR: begin
          // first rising edge after cke high restarts normal decoding
          if (ck_rise)
            st_r <= ST_ACT;
        end
        default: st_r <= ST_ACT;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // mode register read: address capture, latency and four-beat burst
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      mrr_fall_r <= 1'b0;
      mrr_act_r  <= 1'b0;
      mr_hi_r    <= 6'h00;
      rl_cnt_r   <= 8'h00;
      beat_r     <= 3'h0;
      tmrr_r     <= 3'h0;
      dq_o       <= {DQW{1'b0}};
      dq_oe      <= 1'b0;
      dqs_o      <= 1'b0;
      dqs_oe     <= 1'b0;
      mr_data_r  <= 8'h00;
    end else begin
      if (ck_rise && tmrr_r != 3'h0)
        tmrr_r <= tmrr_r - 3'h1;
      if (mrr_cmd) begin
        mr_hi_r    <= ca_d_r[9:4];
        mrr_fall_r <= 1'b1;
        tmrr_r     <= `LRS_TMRR_CK;
      end else if (mrr_fall_r && ck_fall) begin
        // address = {ca1f, ca0f, ca9r..ca4r}
        mrr_fall_r <= 1'b0;
        mrr_act_r  <= 1'b1;
        rl_cnt_r   <= RL[7:0];
        mr_data_r  <= mr_value({ca_d_r[1:0], mr_hi_r});
      end
      if (mrr_act_r && ck_rise) begin
        if (rl_cnt_r != 8'h00) begin
          rl_cnt_r <= rl_cnt_r - 8'h01;
        end else begin
          dq_oe  <= 1'b1;
          dqs_oe <= 1'b1;
          dqs_o  <= 1'b1;
          // value only on the first beat, filler elsewhere
          dq_o   <= (beat_r == 3'h0) ? {{(DQW/8-1){FILL_BYTE}}, mr_data_r}
                                     : {(DQW/8){FILL_BYTE}};
          beat_r <= beat_r + 3'h1;
          if (beat_r == `LRS_BURST_BEATS - 3'h1) begin
            mrr_act_r <= 1'b0;  // burst not interruptible
            beat_r    <= 3'h0;
          end
        end
      end else if (mrr_act_r && ck_fall && dqs_oe) begin
        dqs_o <= 1'b0;
      end else if (!mrr_act_r && ck_fall) begin
        dq_oe  <= 1'b0;
        dqs_oe <= 1'b0;
        dqs_o  <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // ahb-lite slave, zero wait states, always okay
  function [31:0] rd_mux;
    input [7:0] a;
    begin
      case (a)
        `LRS_CTRL_OFS:     rd_mux = {31'h0, out_en_r};
        `LRS_STAT_OFS:     rd_mux = {28'h0, mrr_act_r, mrr_fall_r | (tmrr_r != 3'h0),
                                     st_r == ST_XSR, st_r == ST_SREF};
        `LRS_BANKMASK_OFS: rd_mux = {24'h0, bank_mask_r};
        `LRS_SEGMASK_OFS:  rd_mux = {24'h0, seg_mask_r};
        `LRS_REFCNT_OFS:   rd_mux = {16'h0, refcnt_r};
        `LRS_MR_ADDR_OFS:  rd_mux = {24'h0, mr_addr_r};
        `LRS_MR_DATA_OFS:  rd_mux = {24'h0, mr_value(mr_addr_r)};
        default:           rd_mux = 32'h0;
      endcase
    end
  endfunction

  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      ahb_wr_r    <= 1'b0;
      ahb_a_r     <= 8'h00;
      hrdata      <= 32'h0;
      hreadyout   <= 1'b1;
      hresp       <= 1'b0;
      out_en_r    <= 1'b1;
      bank_mask_r <= `LRS_BANKMASK_RST;
      seg_mask_r  <= `LRS_SEGMASK_RST;
      mr_addr_r   <= 8'h00;
    end else begin
      ahb_wr_r <= hsel & hready & htrans[1] & hwrite;
      if (hsel && hready && htrans[1]) begin
        ahb_a_r <= haddr;
        if (!hwrite)
          hrdata <= rd_mux(haddr);
      end
      if (ahb_wr_r) begin
        case (ahb_a_r)
          `LRS_CTRL_OFS:     out_en_r    <= hwdata[`LRS_CTRL_OUT_EN];
          `LRS_BANKMASK_OFS: bank_mask_r <= hwdata[7:0];
          `LRS_SEGMASK_OFS:  seg_mask_r  <= hwdata[7:0];
          `LRS_MR_ADDR_OFS:  mr_addr_r   <= hwdata[7:0];
          default: ;
        endcase
      end
    end
  end
endmodule

// ---- tb/lrs_core_assertions.sv ----
// port-level assertion checker for the lpddr2 refresh block
`timescale 1ns/1ns
module lrs_core_assertions #(
  parameter       DQW       = 32,
  parameter [7:0] FILL_BYTE = 8'ha5
) (
  input wire           ref_clk,
  input wire           rst_b,
  input wire           cke,
  input wire [DQW-1:0] dq_o,
  input wire           dq_oe,
  input wire           dqs_oe,
  input wire           iref_pulse,
  input wire [7:0]     bank_refresh
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  logic [6:0] oe_cnt_r;
  ////////////////////////////////////////
  // length of the current drive window; a stuck enable overruns it quickly
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b)
      oe_cnt_r <= 7'h00;
    else
      oe_cnt_r <= dq_oe ? oe_cnt_r + 7'h01 : 7'h00;
  end
  ////////////////////////////////////////
  a_bank_with_pulse: assert property (bank_refresh != 8'h00 |-> iref_pulse)
    else $error("bank refresh without internal refresh");
  a_pulse_one_cycle: assert property (iref_pulse |=> !iref_pulse)
    else $error("internal refresh pulse too long");
  a_pulse_in_sref: assert property (iref_pulse |-> !$past(cke, 2) || !$past(cke, 12))
    else $error("internal refresh outside self-refresh");
  a_strobe_with_data: assert property (dq_oe != $past(dq_oe) |-> dqs_oe == dq_oe)
    else $error("strobe enable not with data enable");
  a_burst_max_len: assert property (oe_cnt_r <= 7'd40)
    else $error("read burst too long");
  a_burst_min_len: assert property ($fell(dq_oe) |-> oe_cnt_r >= 7'd24)
    else $error("read burst cut short");
  a_filler_lanes: assert property ($rose(dq_oe) |-> dq_o[DQW-1:8] == {(DQW/8-1){FILL_BYTE}})
    else $error("upper lanes not filler on first beat");
  a_no_read_in_sref: assert property ($rose(dq_oe) |-> $past(cke, 8))
    else $error("read answered while clock enable low");
endmodule
bind lrs_core lrs_core_assertions #(.DQW(DQW), .FILL_BYTE(FILL_BYTE)) u_chk (.ref_clk(ref_clk),
  .rst_b(rst_b), .cke(cke), .dq_o(dq_o), .dq_oe(dq_oe), .dqs_oe(dqs_oe), .iref_pulse(iref_pulse),
  .bank_refresh(bank_refresh));

// ---- tb/lrs_host_model.sv ----
// behavioural host controller driving the link command pins
`timescale 1ns/1ns
module lrs_host_model (
  output logic       link_ck,
  output logic       cke,
  output logic       cs_b,
  output logic [9:0] ca
);
  logic run;
  ////////////////////////////////////////
  // link clock runs free, halted only inside self-refresh
  initial begin
    run = 1'b1;
    link_ck = 1'b0;
    cke = 1'b1;
    cs_b = 1'b1;
    ca = 10'h3ff;
    forever #80 link_ck = run & ~link_ck;
  end
  // rise half set before the rise, fall half after it, then nop; one refresh only,
  // far below the burst and window limits, no burst/pause pattern, no power-down
  task cmd(input [9:0] r, input [9:0] f, input k);
    @(negedge link_ck);
    cke <= k;
    cs_b <= 1'b0;
    ca <= r;
    @(posedge link_ck);
    ca <= f;
    @(negedge link_ck);
    ca <= 10'h003; // nop after every command
  endtask
  // only after the previous burst ended; no array read or write precedes it
  task mrr(input [7:0] ma);
    cmd({ma[5:0], 4'h8}, {8'h00, ma[7:6]}, cke);
  endtask
  // banks are never opened here, so they are idle at entry
  task sref_enter;
    cmd(10'h004, 10'h000, 1'b0);
  endtask
  task stop_clk;
    @(negedge link_ck);
    run = 1'b0;
  endtask
  task sref_exit;
    run = 1'b1;
    repeat (2) @(posedge link_ck);
    @(negedge link_ck);
    cke <= 1'b1;
    repeat (3) @(negedge link_ck);
    cmd(10'h00c, 10'h000, 1'b1);
  endtask
endmodule

// ---- tb/testbench.sv ----
// self-checking bench for the lpddr2 refresh block
`timescale 1ns/1ns
`include "lrs_regs.vh"
module testbench;
  logic        ref_clk, rst_b, hwrite, dq_oe, dqs_o, dqs_oe, iref_pulse, hreadyout, hresp, dqs_q;
  logic        link_ck, cke, cs_b;
  logic [1:0]  htrans;
  logic [7:0]  haddr, bank_refresh, bank_seen;
  logic [9:0]  ca;
  logic [31:0] hwdata, hrdata, dq_o, q;
  logic [39:0] rst_tab [4];
  int          fail_count, n_checks, irefs, beats;
  lrs_host_model host (.link_ck(link_ck), .cke(cke), .cs_b(cs_b), .ca(ca));
  lrs_core #(.RL(3)) uut (.ref_clk(ref_clk), .rst_b(rst_b), .link_ck(link_ck), .cke(cke), .cs_b(cs_b),
    .ca(ca), .dq_o(dq_o), .dq_oe(dq_oe), .dqs_o(dqs_o), .dqs_oe(dqs_oe), .iref_pulse(iref_pulse),
    .bank_refresh(bank_refresh), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hsel(1'b1), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp));
  ////////////////////////////////////////
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  // counts strobe beats and internal refreshes as the device shows them
  always @(posedge ref_clk) begin
    if (dqs_oe === 1'b1 && dqs_o === 1'b1 && dqs_q !== 1'b1)
      beats++;
    dqs_q <= dqs_o;
    if (iref_pulse === 1'b1) begin
      irefs++;
      bank_seen = bank_refresh;
    end
  end
  ////////////////////////////////////////
  task chk(input [31:0] seen, input [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task close_out;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // bounded wait on a design output; running out counts as a mismatch
  task automatic wait_v(ref logic s, input logic v, input int lim);
    int n;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
      if (n > lim) begin
        fail_count++;
        close_out();
      end
    end while (s !== v);
  endtask
  task ahb(input [7:0] a, input w, input [31:0] d);
    @(posedge ref_clk);
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    wait_v(hreadyout, 1'b1, 50);
    htrans <= 2'h0;
    hwdata <= d;
    wait_v(hreadyout, 1'b1, 50);
    q = hrdata;
    chk(hresp, 1'b0);
  endtask
  task mrr_chk(input [7:0] ma, input chk_b, input [7:0] exp);
    beats = 0;
    host.mrr(ma);
    wait_v(dq_oe, 1'b1, 200);
    if (chk_b)
      chk(dq_o[7:0], exp);
    chk(dq_o[31:8], 24'ha5a5a5);
    wait_v(dq_oe, 1'b0, 100);
    chk(beats, 4);
  endtask
  ////////////////////////////////////////
  initial begin
    rst_b = 1'b0;
    haddr = 8'h00;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    rst_tab = '{{`LRS_CTRL_OFS, 32'h1}, {`LRS_BANKMASK_OFS, 32'h0}, {`LRS_SEGMASK_OFS, 32'h0}, {8'h1c, 32'h0}};
    repeat (20) @(posedge ref_clk);
    rst_b <= 1'b1;
    foreach (rst_tab[i]) begin
      ahb(rst_tab[i][39:32], 1'b0, 32'h0);
      chk(q, rst_tab[i][31:0]);
    end
    ahb(`LRS_BANKMASK_OFS, 1'b1, 32'h3c);
    ahb(`LRS_BANKMASK_OFS, 1'b0, 32'h0);
    chk(q, 32'h3c);
    mrr_chk(`LRS_MR_BANKMASK, 1'b1, 8'h3c);
    mrr_chk(8'h3f, 1'b0, 8'h00);
    ahb(`LRS_SEGMASK_OFS, 1'b1, 32'h5a);
    ahb(`LRS_MR_ADDR_OFS, 1'b1, 32'h11);
    ahb(`LRS_MR_DATA_OFS, 1'b0, 32'h0);
    chk(q, 32'h5a);
    mrr_chk(`LRS_MR_SEGMASK, 1'b1, 8'h5a);
    ahb(`LRS_CTRL_OFS, 1'b1, 32'h0);
    host.mrr(`LRS_MR_BANKMASK);
    repeat (60) @(posedge ref_clk) chk(dq_oe, 1'b0);
    ahb(`LRS_CTRL_OFS, 1'b1, 32'h1);
    host.sref_enter();
    ahb(`LRS_STAT_OFS, 1'b0, 32'h0);
    chk(q[0], 1'b1);
    chk(irefs > 0, 1);
    host.mrr(`LRS_MR_BANKMASK);
    repeat (80) @(posedge ref_clk) chk(dq_oe, 1'b0);
    host.stop_clk();
    repeat (800) @(posedge ref_clk);
    chk(irefs >= 3, 1);
    chk(bank_seen, 8'hc3);
    host.sref_exit();
    ahb(`LRS_STAT_OFS, 1'b0, 32'h0);
    chk(q[0], 1'b0);
    ahb(`LRS_REFCNT_OFS, 1'b0, 32'h0);
    chk(q, irefs);
    mrr_chk(`LRS_MR_BANKMASK, 1'b1, 8'h3c);
    close_out();
  end
endmodule
